// File: hdl/osc_div.sv
// divider making the interface chip clock
`timescale 1ns/100ps
`default_nettype none
`include "param_port_defines.svh"
module osc_div (
  input wire logic clk,
  input wire logic reset,
  output logic clk_out
);
  logic [`OSC_CNT_W-1:0] cnt_q, cnt_d;
  logic ph_q, ph_d;
  // ================
  // half-period count; 200 MHz / 20 gives 10 MHz
  always_comb begin
    cnt_d = cnt_q + `OSC_CNT_W'(1);
    ph_d = ph_q;
    if (cnt_q == `OSC_CNT_W'(`OSC_DIV - 1)) begin
      cnt_d = '0;
      ph_d = ~ph_q;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
      ph_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
    end
  end
  assign clk_out = ph_q;
endmodule // osc_div
`default_nettype wire

// File: hdl/param_port_defines.svh
// constants for the tester parameter port
`ifndef PARAM_PORT_DEFINES_SVH
`define PARAM_PORT_DEFINES_SVH
`define NUM_PARAMS 5
`define PARAM_W 8
`define NIB_W 4
`define SEL_W 3
`define ADDR_W 5
// parameter index of each destination
`define P_CLAMP 3'h0
`define P_FWD_WIDTH 3'h1
`define P_FWD_DRIVE 3'h2
`define P_REV_DRIVE 3'h3
`define P_CUR_LIMIT 3'h4
// forbidden clamp codes, inclusive
`define CLAMP_FORBID_LO 8'hc9
`define CLAMP_FORBID_HI 8'hff
// reg addresses
`define A_CLAMP 3'h0
`define A_FWD_WIDTH 3'h1
`define A_FWD_DRIVE 3'h2
`define A_REV_DRIVE 3'h3
`define A_CUR_LIMIT 3'h4
`define A_STATUS 3'h5
`define A_CTRL 3'h6
// timing
`define ACK_DELAY_NS 100
`define CLK_PERIOD_NS 5
`define ACK_DELAY_CYC ((`ACK_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACK_CNT_W 6
`define LAMP_FLASH_NS 200
`define LAMP_FLASH_CYC ((`LAMP_FLASH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_DIV 10
`define OSC_CNT_W 4
`define POR_CYC 16
`define POR_CNT_W 5
// strap code for talker/listener
`define ROLE_STRAP 4'h3
`endif

// File: hdl/param_port_pkg.sv
// types for the tester parameter port
package param_port_pkg;
  typedef logic [7:0] param_t;
  typedef logic [3:0] nibble_t;
  typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT, ACK_HOLD} ack_state_e;
endpackage

// File: hdl/pin_sync.sv
// three-flop input synchroniser, change taken when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(parameter int W = 1) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, o_q;
  logic [W-1:0] o_d;
  // ================
  // settle
  always_comb begin
    o_d = o_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        o_d[i] = s3_q[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      o_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      o_q <= o_d;
    end
  end
  assign dout = o_q;
endmodule // pin_sync
`default_nettype wire

// File: hdl/tester_host_parameter_port.sv
// host-side parameter port of the breakdown tester
// ================
// What this block does
// - five eight-bit parameter registers loaded from the bus port
// - low four data lines form nibble; half-select high means upper half
// - three select lines decode one-of-eight; only addressed register loads
// - clamp codes in the forbidden range are never made active
// - rising receive strobe latches the nibble into chosen half
// - receive strobe returns after a delay as accept-ready
// - breakdown drives the chip service-request input low
// - request-service output drives data line seven low as status
// - talker-active going low clears and re-arms breakdown flag
// - power-up resets chip master reset and clears breakdown flag
// - five-position switch sets chip listen address
// - mode straps fix chip as talker and listener
// - listener-addressed output flashes a panel indicator briefly
// - a 10 MHz clock is given to the chip
// - computer can start a test over the bus
// - current limit is 0 to 255 amperes, loadable from bus or encoder
`timescale 1ns/100ps
`default_nettype none
`include "param_port_defines.svh"
module tester_host_parameter_port (
  input wire logic clk,
  input wire logic reset,
  // interface chip side
  input wire logic rx_strobe_out,
  input wire logic [7:0] bus_data_in,
  input wire logic request_service_out_n,
  input wire logic listener_addressed_out_n,
  input wire logic talker_active_out_n,
  input wire logic [`ADDR_W-1:0] addr_switch,
  output logic rx_accept_ready,
  output logic service_request_in_n,
  output logic status_dio7_out,
  output logic status_dio7_oe,
  output logic chip_master_reset_in_n,
  output logic [3:0] role_strap,
  output logic [`ADDR_W-1:0] bus_addr_out,
  output logic chip_clock_in,
  output logic addressed_lamp,
  // tester side
  input wire logic breakdown,
  input wire logic encoder_load,
  input wire logic [7:0] encoder_value,
  output logic [7:0] clamp_param,
  output logic [7:0] fwd_width_param,
  output logic [7:0] fwd_drive_param,
  output logic [7:0] rev_drive_param,
  output logic [7:0] cur_limit_param,
  output logic test_start,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata
);
  import param_port_pkg::*;

  // ================
  // pin synchronisers
  logic rx_s, svc_req_s, addressed_s, talking_s;
  logic [7:0] dio_s;
  logic [`ADDR_W-1:0] sw_s;
  // active-low pins enter inverted so the cleared synchroniser matches their idle level
  pin_sync #(.W(12)) u_sync_ctl (
    .clk(clk), .reset(reset),
    .din({rx_strobe_out, ~request_service_out_n, ~listener_addressed_out_n, ~talker_active_out_n, bus_data_in}),
    .dout({rx_s, svc_req_s, addressed_s, talking_s, dio_s})
  );
  pin_sync #(.W(`ADDR_W)) u_sync_sw (
    .clk(clk), .reset(reset), .din(addr_switch), .dout(sw_s)
  );
  logic osc_clk;
  osc_div u_osc (.clk(clk), .reset(reset), .clk_out(osc_clk));

  // decode the destination field, one-of-eight
  function automatic logic [7:0] dec8(input logic [2:0] sel);
    dec8 = 8'h01 << sel;
  endfunction
  function automatic logic clamp_bad(input param_t v);
    clamp_bad = (v >= `CLAMP_FORBID_LO) && (v <= `CLAMP_FORBID_HI);
  endfunction

  // ================
  // strobe edge and parameter staging
  logic rx_prev_q, rx_prev_d;
  logic talking_prev_q, talking_prev_d;
  logic addressed_prev_q, addressed_prev_d;
  param_t stage_q [`NUM_PARAMS];
  param_t stage_d [`NUM_PARAMS];
  param_t active_clamp_q, active_clamp_d;
  logic start_q, start_d;
  logic [7:0] en;
  logic rx_rise;
  nibble_t nib;
  assign rx_rise = rx_s & ~rx_prev_q;
  assign nib = dio_s[3:0];
  assign en = dec8(dio_s[6:4]);

  // nibble write into the selected half only; the other half is kept so byte order is free
  always_comb begin
    rx_prev_d = rx_s;
    talking_prev_d = talking_s;
    addressed_prev_d = addressed_s;
    stage_d = stage_q;
    active_clamp_d = active_clamp_q;
    start_d = 1'b0;
    if (rx_rise) begin
      for (int p = 0; p < `NUM_PARAMS; p++) begin
        if (en[p]) begin
          if (dio_s[7]) begin
            stage_d[p][7:4] = nib;
          end else begin
            stage_d[p][3:0] = nib;
          end
        end
      end
      // only destination seven acts as the trigger command; five and six load nothing
      if (dio_s[6:4] == 3'h7) begin
        start_d = 1'b1;
      end
    end
    if (reg_write) begin
      if (reg_addr < 3'(`NUM_PARAMS)) begin
        stage_d[reg_addr] = reg_wdata;
      end
      if (reg_addr == `A_CTRL && reg_wdata[0]) begin
        start_d = 1'b1;
      end
    end
    if (encoder_load) begin
      stage_d[`P_CUR_LIMIT] = encoder_value;
    end
    // the clamp only takes a staged code outside the forbidden band
    if (!clamp_bad(stage_q[`P_CLAMP])) begin
      active_clamp_d = stage_q[`P_CLAMP];
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_prev_q <= 1'b0;
      talking_prev_q <= 1'b0;
      addressed_prev_q <= 1'b0;
      for (int p = 0; p < `NUM_PARAMS; p++) begin
        stage_q[p] <= '0;
      end
      active_clamp_q <= '0;
      start_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_prev_d;
      talking_prev_q <= talking_prev_d;
      addressed_prev_q <= addressed_prev_d;
      stage_q <= stage_d;
      active_clamp_q <= active_clamp_d;
      start_q <= start_d;
    end
  end

  // ================
  // accept-ready delay: hold ack after the strobe until the strobe drops
  ack_state_e ack_q, ack_d;
  logic [`ACK_CNT_W-1:0] ack_cnt_q, ack_cnt_d;
  logic ack_out_q, ack_out_d;
  always_comb begin
    ack_d = ack_q;
    ack_cnt_d = ack_cnt_q;
    ack_out_d = 1'b0;
    unique case (ack_q)
      ACK_IDLE: begin
        ack_cnt_d = '0;
        if (rx_rise) begin
          ack_d = ACK_WAIT;
        end
      end
      ACK_WAIT: begin
        ack_cnt_d = ack_cnt_q + `ACK_CNT_W'(1);
        if (ack_cnt_q == `ACK_CNT_W'(`ACK_DELAY_CYC - 1)) begin
          ack_d = ACK_HOLD;
        end
      end
      ACK_HOLD: begin
        ack_out_d = rx_s;
        if (!rx_s) begin
          ack_d = ACK_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= ACK_IDLE;
      ack_cnt_q <= '0;
      ack_out_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      ack_cnt_q <= ack_cnt_d;
      ack_out_q <= ack_out_d;
    end
  end

  // ================
  // breakdown flag; set beats clear when both land together
  logic flag_q, flag_d;
  logic talk_start;
  assign talk_start = ~talking_prev_q & talking_s; // pin falling shows as a rise here
  always_comb begin
    flag_d = flag_q;
    if (talk_start) begin
      flag_d = 1'b0;
    end
    if (breakdown) begin
      flag_d = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ================
  // power-up chip reset, lamp flash, pin outputs
  logic [`POR_CNT_W-1:0] por_q, por_d;
  logic chip_rst_n_q, chip_rst_n_d;
  logic [7:0] lamp_q, lamp_d;
  logic lamp_on_q, lamp_on_d;
  logic dio7_oe_q, dio7_oe_d;
  logic [`ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    por_d = por_q;
    chip_rst_n_d = 1'b0;
    if (por_q != `POR_CNT_W'(`POR_CYC)) begin
      por_d = por_q + `POR_CNT_W'(1);
    end else begin
      chip_rst_n_d = 1'b1;
    end
    // lamp stretched so a short address pulse stays visible
    lamp_d = lamp_q;
    if (!addressed_prev_q && addressed_s) begin
      lamp_d = 8'(`LAMP_FLASH_CYC);
    end else if (lamp_q != 8'h00) begin
      lamp_d = lamp_q - 8'h01;
    end
    lamp_on_d = (lamp_d != 8'h00);
    dio7_oe_d = svc_req_s;
    addr_d = sw_s;
    rdata_d = 8'h00;
    if (reg_read) begin
      unique case (reg_addr)
        `A_CLAMP: rdata_d = active_clamp_q;
        `A_FWD_WIDTH: rdata_d = stage_q[`P_FWD_WIDTH];
        `A_FWD_DRIVE: rdata_d = stage_q[`P_FWD_DRIVE];
        `A_REV_DRIVE: rdata_d = stage_q[`P_REV_DRIVE];
        `A_CUR_LIMIT: rdata_d = stage_q[`P_CUR_LIMIT];
        `A_STATUS: rdata_d = {5'h00, addressed_s, svc_req_s, flag_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      por_q <= '0;
      chip_rst_n_q <= 1'b0;
      lamp_q <= 8'h00;
      lamp_on_q <= 1'b0;
      dio7_oe_q <= 1'b0;
      addr_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      por_q <= por_d;
      chip_rst_n_q <= chip_rst_n_d;
      lamp_q <= lamp_d;
      lamp_on_q <= lamp_on_d;
      dio7_oe_q <= dio7_oe_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
    end
  end

  // strap and clock outputs are flops or constants
  assign role_strap = `ROLE_STRAP;
  assign chip_clock_in = osc_clk;
  assign rx_accept_ready = ack_out_q;
  assign service_request_in_n = ~flag_q;
  assign status_dio7_out = 1'b0;
  assign status_dio7_oe = dio7_oe_q;
  assign chip_master_reset_in_n = chip_rst_n_q;
  assign bus_addr_out = addr_q;
  assign addressed_lamp = lamp_on_q;
  assign clamp_param = active_clamp_q;
  assign fwd_width_param = stage_q[`P_FWD_WIDTH];
  assign fwd_drive_param = stage_q[`P_FWD_DRIVE];
  assign rev_drive_param = stage_q[`P_REV_DRIVE];
  assign cur_limit_param = stage_q[`P_CUR_LIMIT];
  assign test_start = start_q;
  assign reg_rdata = rdata_q;
endmodule // tester_host_parameter_port
`default_nettype wire

// File: sim/bus_chip_model.sv
// model of the bus interface chip facing the parameter port
`timescale 1ns/100ps
`default_nettype none
module bus_chip_model (
  input wire logic clk,
  input wire logic rx_accept_ready,
  input wire logic service_request_in_n,
  output logic rx_strobe_out,
  output logic [7:0] bus_data_in,
  output logic request_service_out_n,
  output logic listener_addressed_out_n,
  output logic talker_active_out_n
);
  // ==========
  // chip behaviour
  int timeouts = 0; // handshakes that ran out of patience
  initial begin
    rx_strobe_out = 1'b0;
    bus_data_in = 8'h00;
    listener_addressed_out_n = 1'b1;
    talker_active_out_n = 1'b1;
    request_service_out_n = 1'b1;
  end
  // chip answers a service request one cycle later
  always @(posedge clk) request_service_out_n <= service_request_in_n;
  // one byte: nibble plus destination, held until accepted
  task automatic send(input logic [7:0] b);
    int n;
    @(posedge clk);
    rx_strobe_out <= 1'b1;
    bus_data_in <= b;
    n = 0;
    do begin @(posedge clk); n++; end while (rx_accept_ready !== 1'b1 && n < 100);
    if (rx_accept_ready !== 1'b1) timeouts++;
    rx_strobe_out <= 1'b0;
    bus_data_in <= ~b; // released lines must not keep the byte
    n = 0;
    do begin @(posedge clk); n++; end while (rx_accept_ready !== 1'b0 && n < 100);
    if (rx_accept_ready !== 1'b0) timeouts++;
  endtask
  // serial poll makes the chip an active talker for a while
  task automatic poll();
    @(posedge clk);
    talker_active_out_n <= 1'b0;
    repeat (4) @(posedge clk);
    talker_active_out_n <= 1'b1;
  endtask
  task automatic address();
    @(posedge clk);
    listener_addressed_out_n <= 1'b0;
    repeat (4) @(posedge clk);
    listener_addressed_out_n <= 1'b1;
  endtask
endmodule // bus_chip_model
`default_nettype wire

// File: sim/param_port_checker.sv
// checker for the tester parameter port
`timescale 1ns/100ps
`default_nettype none
module param_port_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_strobe_out,
  input wire logic request_service_out_n,
  input wire logic listener_addressed_out_n,
  input wire logic talker_active_out_n,
  input wire logic breakdown,
  input wire logic rx_accept_ready,
  input wire logic service_request_in_n,
  input wire logic status_dio7_out,
  input wire logic status_dio7_oe,
  input wire logic chip_master_reset_in_n,
  input wire logic [3:0] role_strap,
  input wire logic chip_clock_in,
  input wire logic addressed_lamp,
  input wire logic [7:0] clamp_param
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // properties
  ack_early_a: assert property ($rose(rx_strobe_out) |-> !rx_accept_ready[*8])
    else $error("accept ready came too early");
  ack_late_a: assert property ($rose(rx_strobe_out) |-> ##[8:40] rx_accept_ready)
    else $error("accept ready never came");
  flag_set_a: assert property (breakdown |=> !service_request_in_n)
    else $error("breakdown did not request service");
  flag_hold_a: assert property (talker_active_out_n[*7] ##0 !service_request_in_n |=> !service_request_in_n)
    else $error("service request dropped by itself");
  flag_clear_a: assert property ($fell(talker_active_out_n) && !breakdown |-> ##[1:8] service_request_in_n)
    else $error("talker active did not clear the flag");
  dio7_drive_a: assert property (!request_service_out_n[*6] |-> status_dio7_oe && !status_dio7_out)
    else $error("status line not pulled low");
  dio7_idle_a: assert property (request_service_out_n[*6] |-> !status_dio7_oe)
    else $error("status line driven while idle");
  reset_state_a: assert property (disable iff (1'b0) reset |=> service_request_in_n && !chip_master_reset_in_n && clamp_param == 8'h00)
    else $error("reset state wrong");
  clamp_ok_a: assert property (!(clamp_param inside {[8'hc9:8'hff]}))
    else $error("forbidden clamp code active");
  role_strap_a: assert property (role_strap == 4'h3)
    else $error("role strap wrong");
  chip_clock_a: assert property ($rose(chip_clock_in) |-> ##10 $fell(chip_clock_in) ##10 $rose(chip_clock_in))
    else $error("chip clock period wrong");
  lamp_flash_a: assert property ($fell(listener_addressed_out_n) |-> ##[1:12] addressed_lamp)
    else $error("addressed lamp did not light");
  // main scenarios reached
  cover property (rx_strobe_out && rx_accept_ready);
  cover property ($fell(service_request_in_n));
  cover property ($rose(service_request_in_n));
endmodule // param_port_checker
bind tester_host_parameter_port param_port_checker i_param_port_checker (.clk, .reset, .rx_strobe_out,
  .request_service_out_n, .listener_addressed_out_n, .talker_active_out_n, .breakdown, .rx_accept_ready,
  .service_request_in_n, .status_dio7_out, .status_dio7_oe, .chip_master_reset_in_n, .role_strap,
  .chip_clock_in, .addressed_lamp, .clamp_param);
`default_nettype wire

// File: sim/tester_host_parameter_port_tb.sv
// testbench for the tester parameter port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tester_host_parameter_port_tb;
  logic clk, reset, rx_strobe_out, request_service_out_n, listener_addressed_out_n, talker_active_out_n;
  logic rx_accept_ready, service_request_in_n, status_dio7_out, status_dio7_oe, chip_master_reset_in_n;
  logic chip_clock_in, addressed_lamp, breakdown, encoder_load, test_start, reg_write, reg_read;
  logic [7:0] bus_data_in, encoder_value, reg_wdata, reg_rdata, q;
  logic [7:0] clamp_param, fwd_width_param, fwd_drive_param, rev_drive_param, cur_limit_param;
  logic [4:0] addr_switch, bus_addr_out;
  logic [3:0] role_strap;
  logic [2:0] reg_addr;
  logic [7:0] got [5], stg [5], ex [5];
  logic [7:0] seq [9] = '{8'hbc, 8'h8c, 8'h08, 8'h09, 8'h8f, 8'h0f, 8'h00, 8'h8c, 8'hd5};
  int error_cnt = 0, checks_done = 0, cyc = 0, starts = 0, n;
  tester_host_parameter_port i_tester_host_parameter_port (.*);
  bus_chip_model i_bus_chip_model (.clk, .rx_accept_ready, .service_request_in_n, .rx_strobe_out, .bus_data_in,
    .request_service_out_n, .listener_addressed_out_n, .talker_active_out_n);
  always #2.5 clk = ~clk;
  always_comb got = '{clamp_param, fwd_width_param, fwd_drive_param, rev_drive_param, cur_limit_param};
  // ==========
  // helpers
  always @(posedge clk) begin
    cyc++;
    if (test_start === 1'b1) starts++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // staged value always kept; clamp only made active outside the forbidden range
  task automatic upd(input int d, input logic [7:0] v);
    stg[d] = v;
    if (d != 0 || v < 8'hc9) ex[d] = v;
  endtask
  task automatic chk_all();
    for (int i = 0; i < 5; i++) `CHK("param", ex[i], got[i])
  endtask
  task automatic send_chk(input logic [7:0] b);
    int d;
    d = b[6:4];
    i_bus_chip_model.send(b);
    @(posedge clk);
    if (d < 5) upd(d, b[7] ? {b[3:0], stg[d][3:0]} : {stg[d][7:4], b[3:0]});
    chk_all();
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 r = reg_rdata;
    @(posedge clk);
  endtask
  // ==========
  // main sequence
  initial begin
    {clk, breakdown, encoder_load, reg_write, reg_read, reg_addr, reg_wdata, encoder_value} = '0;
    reset = 1'b1;
    addr_switch = 5'h15;
    stg = '{default: 8'h00};
    ex = '{default: 8'h00};
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 `CHK("mr_n", 1'b0, chip_master_reset_in_n)
    chk_all();
    for (int p = 0; p < 5; p++) begin
      send_chk({1'b0, 3'(p), 4'(10 - p)});
      send_chk({1'b1, 3'(p), 4'(p + 1)});
    end
    // clamp edges of the forbidden range, then destinations with no register
    foreach (seq[i]) send_chk(seq[i]);
    send_chk(8'h63);
    `CHK("mr_n", 1'b1, chip_master_reset_in_n)
    `CHK("addr", 5'h15, bus_addr_out)
    `CHK("strap", 4'h3, role_strap)
    wr(3'h4, 8'h64);
    upd(4, 8'h64);
    rd(3'h4, q);
    `CHK("rdata", 8'h64, q)
    wr(3'h0, 8'hd0);
    upd(0, 8'hd0);
    rd(3'h7, q);
    `CHK("unmapped", 8'h00, q)
    encoder_value <= 8'hff;
    encoder_load <= 1'b1;
    @(posedge clk);
    encoder_load <= 1'b0;
    upd(4, 8'hff);
    repeat (2) @(posedge clk);
    chk_all();
    i_bus_chip_model.send(8'hf0);
    wr(3'h6, 8'h01);
    repeat (3) @(posedge clk);
    `CHK("starts", 2, starts)
    breakdown <= 1'b1;
    @(posedge clk);
    breakdown <= 1'b0;
    #1 `CHK("srq_n", 1'b0, service_request_in_n)
    repeat (10) @(posedge clk);
    `CHK("srq_n", 1'b0, service_request_in_n)
    `CHK("dio7_oe", 1'b1, status_dio7_oe)
    rd(3'h5, q);
    `CHK("status", 8'h03, q)
    i_bus_chip_model.poll();
    repeat (8) @(posedge clk);
    `CHK("srq_n", 1'b1, service_request_in_n)
    breakdown <= 1'b1;
    @(posedge clk);
    breakdown <= 1'b0;
    #1 `CHK("rearm", 1'b0, service_request_in_n)
    i_bus_chip_model.address();
    n = 0;
    while (addressed_lamp !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    `CHK("lamp", 1'b1, addressed_lamp)
    repeat (45) @(posedge clk);
    `CHK("lamp off", 1'b0, addressed_lamp)
    // second reset in mid-run with the flag set and the service request pin still low
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("reset srq_n", 1'b1, service_request_in_n)
    `CHK("reset lamp", 1'b0, addressed_lamp)
    `CHK("reset clamp", 8'h00, clamp_param)
    `CHK("reset limit", 8'h00, cur_limit_param)
    `CHK("send timeouts", 0, i_bus_chip_model.timeouts)
    end_of_test();
  end
endmodule // tester_host_parameter_port_tb
`default_nettype wire
